// ==== sim/vfs_host.sv ====
// Bus host model for the serial command link
`include "vfs_defines.vh"
module vfs_host (
	output logic scl,
	output wire logic sda,
	input wire logic sda_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic drv = 1'b1;
	logic [7:0] rb;
	// Open drain with pull-up, so a released line reads high
	assign sda = drv & ~sda_oe;
	initial scl = 1'b1;
	// Data moves only early in the low phase, 8 ns after the fall, clear of both synchronised clock edges
	task bit_io(input logic b, output logic r);
		drv = b;
		#32 scl = 1'b1;
		#12 r = sda;
		#12 scl = 1'b0;
		#8;
	endtask
	task byte_io(input logic [7:0] d, input logic nak, output logic [7:0] q);
		logic a;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(nak, a);
	endtask
	task xfer(input logic [7:0] cmd, input logic [15:0] wd, input int nw, nr,
		output logic [15:0] rd);
		rd = 16'h0;
		drv = 1'b0;
		#20 scl = 1'b0;
		#8 byte_io({`VFS_DEV_ADDR, 1'b0}, 1'b1, rb);
		byte_io(cmd, 1'b1, rb);
		for (int i = 0; i < nw; i++) byte_io(wd[8*i +: 8], 1'b1, rb);
		if (nr > 0) begin
			// Long wait lets the device drop its acknowledge first
			drv = 1'b1;
			#40 scl = 1'b1;
			#20 drv = 1'b0;
			#20 scl = 1'b0;
			#8 byte_io({`VFS_DEV_ADDR, 1'b1}, 1'b1, rb);
			for (int i = 0; i < nr; i++) begin
				byte_io(8'hff, i == nr - 1, rb);
				rd[8*i +: 8] = rb;
			end
		end
		drv = 1'b0;
		#20 scl = 1'b1;
		#20 drv = 1'b1;
		#20;
	endtask
endmodule

// ==== sim/vfs_props.sv ====
// Port assertions for the fault supervisor
module vfs_props (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic pmb_scl,
	input wire logic pmb_sda_out,
	input wire logic pmb_sda_oe,
	input wire logic operation_on,
	input wire logic bias_ok,
	input wire logic other_fault,
	input wire logic output_run,
	input wire logic alert_line_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	quiet_reset_a: assert property ($rose(reset_n) |-> alert_line_n && !output_run)
		else $error("bad state after reset");
	run_cause_a: assert property ($rose(output_run) |-> $past(operation_on) && $past(bias_ok))
		else $error("run without request");
	bias_stop_a: assert property (!bias_ok |-> ##[0:3] !output_run)
		else $error("run kept without bias");
	other_stop_a: assert property (other_fault |-> ##[0:3] !output_run)
		else $error("run kept on other fault");
	stop_alert_a: assert property ($fell(output_run)
		&& $past(operation_on) && $past(bias_ok) && !$past(other_fault) |-> !alert_line_n)
		else $error("stop without alert");
	alert_cause_a: assert property ($fell(alert_line_n) |-> $past(output_run))
		else $error("alert outside run");
	alert_clear_a: assert property ($rose(alert_line_n) |-> !pmb_scl)
		else $error("alert freed off a command");
	ack_phase_a: assert property ($rose(pmb_sda_oe) |-> !pmb_scl)
		else $error("data pulled with clock high");
	sda_value_a: assert property (!pmb_sda_out)
		else $error("data value driven high");
endmodule

bind vfs_supervisor vfs_props u_props (
	.clk_sys(clk_sys),
	.reset_n(reset_n),
	.pmb_scl(pmb_scl),
	.pmb_sda_out(pmb_sda_out),
	.pmb_sda_oe(pmb_sda_oe),
	.operation_on(operation_on),
	.bias_ok(bias_ok),
	.other_fault(other_fault),
	.output_run(output_run),
	.alert_line_n(alert_line_n)
);

// ==== sim/vfs_supervisor_tb.sv ====
// Self-checking bench for the fault supervisor
`include "vfs_defines.vh"
module vfs_supervisor_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int UNIT = 50;
	logic clk_sys = 0, reset_n = 0, scl, sda, oe, run, alert_n;
	logic en = 0, op = 0, bias = 1, oth = 0, good = 0;
	logic [15:0] strap, vout = 0, rd, seen;
	logic [15:0] exp_q[$];
	string name_q[$];
	int bad_count = 0, checks = 0;
	event got;
	always #2.5 clk_sys = ~clk_sys;
	vfs_host host (.scl(scl), .sda(sda), .sda_oe(oe));
	vfs_supervisor #(.RETRY_UNIT_CYCLES(UNIT)) dut (.clk_sys(clk_sys), .reset_n(reset_n),
		.pmb_scl(scl), .pmb_sda_in(sda), .pmb_sda_out(), .pmb_sda_oe(oe),
		.setpoint_strap(strap), .enable_pin(en), .operation_on(op), .bias_ok(bias),
		.other_fault(oth), .output_good_flag(good), .vout_measured(vout),
		.output_run(run), .alert_line_n(alert_n));
	always @(got) begin
		checks++;
		if (seen !== exp_q[0]) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name_q[0], exp_q[0], seen);
		end
		void'(exp_q.pop_front());
		void'(name_q.pop_front());
	end
	task chk(input string n, input logic [15:0] e, v);
		name_q.push_back(n);
		exp_q.push_back(e);
		seen = v;
		-> got;
		// Next stimulus then lands on a clock edge
		@(posedge clk_sys);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task wait_run(input logic lv, output int n);
		n = 0;
		while (run !== lv && n < 9999) begin
			@(posedge clk_sys);
			n++;
		end
		if (run !== lv) begin
			bad_count++;
			$display("CHECK FAILED wait_run expected %b seen %b", lv, run);
		end
	endtask
	initial begin
		#400us;
		bad_count++;
		tally_and_finish();
	end
	initial begin
		int t, n, d;
		logic [7:0] c;
		logic [15:0] v;
		void'($urandom(73222));
		strap <= 16'($urandom_range(61440, 4096));
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		repeat (8) @(posedge clk_sys);
		t = strap * 11 / 10;
		host.xfer(`VFS_CMD_OV_LIMIT, 0, 0, 2, rd);
		chk("ov dflt", t > 65535 ? 16'hffff : 16'(t), rd);
		host.xfer(`VFS_CMD_UV_LIMIT, 0, 0, 2, rd);
		chk("uv dflt", 16'(strap * 17 / 20), rd);
		host.xfer(`VFS_CMD_OV_RESP, 0, 0, 1, rd);
		chk("resp dflt", `VFS_OVR_RESET, rd);
		host.xfer(8'h55, 0, 0, 1, rd);
		chk("unmapped", 16'hff, rd);
		for (int i = 0; i < 2; i++) begin
			c = i ? `VFS_CMD_UV_LIMIT : `VFS_CMD_OV_LIMIT;
			v = 16'($urandom);
			host.xfer(c, v, 2, 0, rd);
			host.xfer(c, 0, 0, 2, rd);
			chk("limit", v, rd);
		end
		$display("register test done");
		host.xfer(`VFS_CMD_OV_LIMIT, 16'h4000, 2, 0, rd);
		host.xfer(`VFS_CMD_UV_LIMIT, 16'h2000, 2, 0, rd); // Below the good level
		@(posedge clk_sys) en <= 1'b1;
		op <= 1'b1;
		vout <= 16'h1000;
		wait_run(1'b1, n);
		repeat (20) @(posedge clk_sys);
		chk("uv masked", 16'h1, 16'(alert_n));
		@(posedge clk_sys) good <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("uv alert", 16'h0, 16'(alert_n));
		vout <= 16'h3000;
		// Fault gone, bit must still read back set
		host.xfer(`VFS_CMD_STATUS, 0, 0, 1, rd);
		chk("uv status", 16'h10, rd);
		host.xfer(`VFS_CMD_CLEAR, 0, 0, 0, rd);
		chk("uv cleared", 16'h1, 16'(alert_n));
		@(posedge clk_sys) vout <= 16'h5000;
		wait_run(1'b0, n);
		chk("ov alert", 16'h0, 16'(alert_n));
		vout <= 16'h3000;
		repeat (3 * UNIT) @(posedge clk_sys);
		chk("no retry", 16'h0, 16'(run));
		host.xfer(`VFS_CMD_STATUS, 0, 0, 1, rd);
		chk("ov status", 16'h80, rd);
		host.xfer(`VFS_CMD_CLEAR, 0, 0, 0, rd);
		chk("cleared", 16'h1, 16'(alert_n));
		@(posedge clk_sys) op <= 1'b0;
		repeat (4) @(posedge clk_sys);
		op <= 1'b1;
		wait_run(1'b1, n);
		chk("restart", 16'h1, 16'(run));
		$display("fault test done");
		for (int i = 0; i < 3; i++) begin
			d = $urandom_range(7, 0);
			@(posedge clk_sys) op <= 1'b0;
			host.xfer(`VFS_CMD_OV_RESP, 16'((i == 1 ? 8'hf8 : 8'hb8) | d), 1, 0, rd);
			host.xfer(`VFS_CMD_CLEAR, 0, 0, 0, rd);
			@(posedge clk_sys) vout <= 16'h5000;
			op <= 1'b1;
			wait_run(1'b1, n);
			wait_run(1'b0, n);
			wait_run(1'b1, t);
			chk("retry gap", 16'((d + 1) * UNIT), 16'(n + t));
		end
		@(posedge clk_sys) vout <= 16'h3000;
		repeat (8 * UNIT) @(posedge clk_sys);
		wait_run(1'b1, n);
		@(posedge clk_sys) bias <= 1'b0;
		repeat (6) @(posedge clk_sys);
		chk("bias loss", 16'h0, 16'(run));
		bias <= 1'b1;
		wait_run(1'b1, n);
		oth <= 1'b1;
		repeat (6) @(posedge clk_sys);
		chk("other fault", 16'h0, 16'(run));
		$display("retry test done");
		tally_and_finish();
	end
endmodule

// ==== verilog/vfs_defines.vh ====
// Command codes, field positions, reset values and timing for the output fault supervisor
`ifndef VFS_DEFINES_VH
`define VFS_DEFINES_VH

`define VFS_CMD_CLEAR 8'h03
`define VFS_CMD_OV_LIMIT 8'h40
`define VFS_CMD_OV_RESP 8'h41
`define VFS_CMD_UV_LIMIT 8'h44
`define VFS_CMD_STATUS 8'h7a

`define VFS_STAT_OV_BIT 7
`define VFS_STAT_UV_BIT 4

`define VFS_BEH_BIT 7
`define VFS_RETRY_MSB 5
`define VFS_RETRY_LSB 3
`define VFS_DELAY_MSB 2
`define VFS_DELAY_LSB 0
`define VFS_RETRY_CONT 3'h7

`define VFS_OVR_RESET 8'h80
`define VFS_OV_NUM 32'h0000000b
`define VFS_OV_DEN 32'h0000000a
`define VFS_UV_NUM 32'h00000011
`define VFS_UV_DEN 32'h00000014

`define VFS_CLK_NS 5
`define VFS_RETRY_UNIT_NS 35000000

// Arbitrary bus address, not tied to any product
`define VFS_DEV_ADDR 7'h10
`define VFS_STRAP_SETTLE 2'h3
`define VFS_BYTE_BITS 4'h8
`define VFS_NO_DATA 8'hff

`endif

// ==== verilog/vfs_supervisor.v ====
// Output voltage fault supervisor with serial command port and retry state machine
`include "vfs_defines.vh"

//Contract
//- Overvoltage threshold 16-bit RW, LSB 2^-13 V
//- Overvoltage threshold resets to 1.10 x strap
//- Undervoltage threshold 16-bit RW, LSB 2^-13 V
//- Undervoltage threshold resets to 0.85 x strap
//- Undervoltage ignored before good, ramping, disabled
//- Reaction byte RW, reset 80h or BFh
//- Behaviour 10/11 disables output, then retry
//- Fault drives alert low, sticky until clear
//- Retry 000 keeps output off until restart
//- Retry 111 restarts until off or fault
//- Retry spacing (delay+1) x 35ms
//- Spacing measured start to start
module vfs_supervisor #(
	parameter [6:0] DEV_ADDR = `VFS_DEV_ADDR,
	parameter [7:0] OVR_RESET = `VFS_OVR_RESET,
	parameter [31:0] RETRY_UNIT_CYCLES = `VFS_RETRY_UNIT_NS / `VFS_CLK_NS
) (
	input wire clk_sys,
	input wire reset_n,
	input wire pmb_scl,
	input wire pmb_sda_in,
	output reg pmb_sda_out,
	output reg pmb_sda_oe,
	input wire [15:0] setpoint_strap,
	input wire enable_pin,
	input wire operation_on,
	input wire bias_ok,
	input wire other_fault,
	input wire output_good_flag,
	input wire [15:0] vout_measured,
	output reg output_run,
	output reg alert_line_n
);

	localparam [2:0] S_IDLE = 3'h0;
	localparam [2:0] S_RX = 3'h1;
	localparam [2:0] S_RX_ACK = 3'h2;
	localparam [2:0] S_TX = 3'h3;
	localparam [2:0] S_TX_ACK = 3'h4;

	localparam [1:0] F_OFF = 2'h0;
	localparam [1:0] F_RUN = 2'h1;
	localparam [1:0] F_WAIT = 2'h2;
	localparam [1:0] F_HOLD = 2'h3;

	wire [18:0] sync_bus;
	wire scl_s;
	wire sda_s;
	wire en_s;
	wire [15:0] strap_s;

	vfs_sync2 #(
		.WIDTH(19)
	) u_sync (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.async_in({pmb_scl, pmb_sda_in, enable_pin, setpoint_strap}),
		.sync_out(sync_bus)
	);

	assign scl_s = sync_bus[18];
	assign sda_s = sync_bus[17];
	assign en_s = sync_bus[16];
	assign strap_s = sync_bus[15:0];

	reg scl_d;
	reg sda_d;
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
	wire bus_stop = scl_s & scl_d & ~sda_d & sda_s;

	reg [15:0] overvoltage_threshold;
	reg [7:0] overvoltage_reaction;
	reg [15:0] undervoltage_threshold;
	reg ov_flag;
	reg uv_flag;

	reg [2:0] link_state;
	reg [3:0] bit_cnt;
	reg [7:0] shreg;
	reg is_addr;
	reg rw;
	reg [1:0] byte_idx;
	reg tx_idx;
	reg [7:0] cmd;
	reg [7:0] wr_lo;
	reg clear_req;
	reg [1:0] settle_cnt;
	reg strap_done;

	// Default thresholds scaled from the captured strap; overflow saturates
	wire [31:0] ov_calc = ({16'h0000, strap_s} * `VFS_OV_NUM) / `VFS_OV_DEN;
	wire [31:0] uv_calc = ({16'h0000, strap_s} * `VFS_UV_NUM) / `VFS_UV_DEN;
	wire [15:0] ov_default = (|ov_calc[31:16]) ? 16'hffff : ov_calc[15:0];
	wire [15:0] uv_default = uv_calc[15:0];

	reg [15:0] rd_word;
	wire [7:0] rd_byte = tx_idx ? rd_word[15:8] : rd_word[7:0];
	wire [7:0] status_byte;

	assign status_byte = {ov_flag, 2'h0, uv_flag, 4'h0};

	always @* begin
		case (cmd)
			`VFS_CMD_OV_LIMIT: rd_word = overvoltage_threshold;
			`VFS_CMD_OV_RESP: rd_word = {8'h00, overvoltage_reaction};
			`VFS_CMD_UV_LIMIT: rd_word = undervoltage_threshold;
			`VFS_CMD_STATUS: rd_word = {8'h00, status_byte};
			default: rd_word = {`VFS_NO_DATA, `VFS_NO_DATA};
		endcase
	end

	// Serial command port; acts on edges of the sampled link clock
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
			link_state <= S_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			is_addr <= 1'b0;
			rw <= 1'b0;
			byte_idx <= 2'h0;
			tx_idx <= 1'b0;
			cmd <= 8'h00;
			wr_lo <= 8'h00;
			clear_req <= 1'b0;
			pmb_sda_out <= 1'b0;
			pmb_sda_oe <= 1'b0;
			overvoltage_threshold <= 16'h0000;
			undervoltage_threshold <= 16'h0000;
			overvoltage_reaction <= OVR_RESET;
			settle_cnt <= 2'h0;
			strap_done <= 1'b0;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			clear_req <= 1'b0;
			pmb_sda_out <= 1'b0;
			// Strap is sampled only once it has crossed the synchroniser
			if (!strap_done) begin
				if (settle_cnt == `VFS_STRAP_SETTLE) begin
					strap_done <= 1'b1;
					overvoltage_threshold <= ov_default;
					undervoltage_threshold <= uv_default;
				end else begin
					settle_cnt <= settle_cnt + 2'h1;
				end
			end
			if (bus_start) begin
				link_state <= S_RX;
				bit_cnt <= 4'h0;
				is_addr <= 1'b1;
				byte_idx <= 2'h0;
				pmb_sda_oe <= 1'b0;
			end else if (bus_stop) begin
				link_state <= S_IDLE;
				pmb_sda_oe <= 1'b0;
			end else begin
				case (link_state)
					S_IDLE: begin
						pmb_sda_oe <= 1'b0;
					end
					S_RX: begin
						if (scl_rise && bit_cnt != `VFS_BYTE_BITS) begin
							shreg <= {shreg[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == `VFS_BYTE_BITS) begin
							bit_cnt <= 4'h0;
							if (is_addr) begin
								is_addr <= 1'b0;
								if (shreg[7:1] == DEV_ADDR) begin
									rw <= shreg[0];
									tx_idx <= 1'b0;
									pmb_sda_oe <= 1'b1;
									link_state <= S_RX_ACK;
								end else begin
									link_state <= S_IDLE;
								end
							end else begin
								pmb_sda_oe <= 1'b1;
								link_state <= S_RX_ACK;
								if (byte_idx != 2'h3) begin
									byte_idx <= byte_idx + 2'h1;
								end
								if (byte_idx == 2'h0) begin
									cmd <= shreg;
									if (shreg == `VFS_CMD_CLEAR) begin
										clear_req <= 1'b1;
									end
								end else if (byte_idx == 2'h1) begin
									wr_lo <= shreg;
									if (cmd == `VFS_CMD_OV_RESP) begin
										overvoltage_reaction <= shreg;
									end
								end else if (byte_idx == 2'h2) begin
									if (cmd == `VFS_CMD_OV_LIMIT) begin
										overvoltage_threshold <= {shreg, wr_lo};
									end
									if (cmd == `VFS_CMD_UV_LIMIT) begin
										undervoltage_threshold <= {shreg, wr_lo};
									end
								end
							end
						end
					end
					S_RX_ACK: begin
						if (scl_fall) begin
							if (rw) begin
								shreg <= rd_byte;
								pmb_sda_oe <= ~rd_byte[7];
								bit_cnt <= 4'h1;
								link_state <= S_TX;
							end else begin
								pmb_sda_oe <= 1'b0;
								link_state <= S_RX;
							end
						end
					end
					S_TX: begin
						if (scl_fall) begin
							if (bit_cnt == `VFS_BYTE_BITS) begin
								pmb_sda_oe <= 1'b0;
								link_state <= S_TX_ACK;
							end else begin
								pmb_sda_oe <= ~shreg[3'h7 - bit_cnt[2:0]];
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					S_TX_ACK: begin
						if (scl_rise) begin
							tx_idx <= 1'b1;
							// Host NACK ends the read; wait for stop
							link_state <= sda_s ? S_IDLE : S_RX_ACK;
						end
					end
					default: begin
						link_state <= S_IDLE;
						pmb_sda_oe <= 1'b0;
					end
				endcase
			end
		end
	end

	// Fault response state machine
	reg [1:0] fault_state;
	reg [1:0] next_state;
	reg [31:0] start_timer;
	reg pg_seen;
	wire want_on = en_s & operation_on & bias_ok;
	wire stop_now = ~want_on | other_fault;
	wire running = (fault_state == F_RUN);
	wire ov_detect = running & (vout_measured > overvoltage_threshold);
	wire uv_detect = running & pg_seen & (vout_measured < undervoltage_threshold);
	wire ov_handled = ov_detect & overvoltage_reaction[`VFS_BEH_BIT];
	wire [2:0] retry_set = overvoltage_reaction[`VFS_RETRY_MSB:`VFS_RETRY_LSB];
	wire [2:0] retry_delay = overvoltage_reaction[`VFS_DELAY_MSB:`VFS_DELAY_LSB];
	wire [31:0] retry_interval = ({29'h0, retry_delay} + 32'h1) * RETRY_UNIT_CYCLES;
	wire next_ov = ov_detect | (ov_flag & ~clear_req);
	wire next_uv = uv_detect | (uv_flag & ~clear_req);

	always @* begin
		case (fault_state)
			F_OFF: next_state = stop_now ? F_OFF : F_RUN;
			F_RUN: begin
				if (stop_now) begin
					next_state = F_OFF;
				end else if (ov_handled) begin
					// Unused retry codes behave as no retry
					next_state = (retry_set == `VFS_RETRY_CONT) ? F_WAIT : F_HOLD;
				end else begin
					next_state = F_RUN;
				end
			end
			F_WAIT: begin
				if (stop_now) begin
					next_state = F_OFF;
				end else if (start_timer >= retry_interval - 32'h1) begin
					next_state = F_RUN;
				end else begin
					next_state = F_WAIT;
				end
			end
			F_HOLD: next_state = want_on ? F_HOLD : F_OFF;
			default: next_state = F_OFF;
		endcase
	end

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fault_state <= F_OFF;
			start_timer <= 32'h0;
			pg_seen <= 1'b0;
			ov_flag <= 1'b0;
			uv_flag <= 1'b0;
			output_run <= 1'b0;
			alert_line_n <= 1'b1;
		end else begin
			fault_state <= next_state;
			// Set wins over a clear arriving in the same cycle
			ov_flag <= next_ov;
			uv_flag <= next_uv;
			alert_line_n <= ~(next_ov | next_uv);
			output_run <= (next_state == F_RUN);
			// Timer restarts at every attempt start, not at the fault
			if (next_state == F_RUN && fault_state != F_RUN) begin
				start_timer <= 32'h0;
				pg_seen <= 1'b0;
			end else begin
				if (start_timer != 32'hffffffff) begin
					start_timer <= start_timer + 32'h1;
				end
				if (running && output_good_flag) begin
					pg_seen <= 1'b1;
				end
			end
		end
	end

endmodule

// ==== verilog/vfs_sync2.v ====
// Two flip-flop synchroniser for inputs from outside the clk_sys domain
module vfs_sync2 #(
	parameter WIDTH = 1
) (
	input wire clk_sys,
	input wire reset_n,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta;

	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			meta <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule
